// ==== tpio_params.svh ====
`ifndef TPIO_PARAMS_SVH
`define TPIO_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TPIO_OFS_IO_HI0 8'h00
`define TPIO_OFS_IO_LO0 8'h04
`define TPIO_OFS_IO_CH1 8'h08
`define TPIO_OFS_IO_CH2 8'h0C
`define TPIO_OFS_MODE0 8'h10
`define TPIO_OFS_MODE1 8'h14
`define TPIO_OFS_MODE2 8'h18
`define TPIO_OFS_START 8'h1C
`define TPIO_OFS_CAP_BASE 8'h20

// ----------------------------------------
// reset values and field layout
// ----------------------------------------
`define TPIO_IO_RESET 8'h00
`define TPIO_MODE_RESET 6'h00
`define TPIO_START_RESET 3'h0
`define TPIO_FLD_TOP 3
`define TPIO_FLD_LVL 2
`define TPIO_MODE_BFA 4
`define TPIO_MODE_BFB 5
`define TPIO_MODE_RSVD 2'h3
`define TPIO_MD_PWM1 4'h2
`define TPIO_MD_PWM2 4'h3
`define TPIO_ACT_OFF 2'h0
`define TPIO_ACT_LOW 2'h1
`define TPIO_ACT_HIGH 2'h2
`define TPIO_ACT_TOG 2'h3
`define TPIO_CW 16

`endif

// ==== tpio_pkg.sv ====
`include "tpio_params.svh"

package tpio_pkg;

  // ----------------------------------------
  // function of one general register
  // ----------------------------------------
  typedef enum logic [2:0] {
    TPIO_FN_OFF = 3'b001,
    TPIO_FN_OC = 3'b010,
    TPIO_FN_IC = 3'b100
  } tpio_func_t;

  // ----------------------------------------
  // carriers and state
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] field;
    logic en;
  } tpio_cfg_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic hit;
    logic cap_stb;
    logic [15:0] cap_val;
  } tpio_cap_t;

  typedef struct packed {
    logic [3:0][7:0] io;
    logic [2:0][5:0] mode;
    logic [2:0] run;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic ack;
    logic [31:0] rdat;
  } tpio_regs_t;

endpackage

// ==== tpio_cap_unit.sv ====
`timescale 1ns/1ps
`include "tpio_params.svh"

module tpio_cap_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  input tpio_pkg::tpio_cfg_t cfg,
  input wire logic [15:0] count,
  output logic cap_stb,
  output logic [15:0] cap_val
);

  tpio_pkg::tpio_cap_t st;
  tpio_pkg::tpio_cap_t next_st;
  tpio_pkg::tpio_func_t fn;
  logic rise;
  logic fall;
  logic qual;

  // ----------------------------------------
  // edge qualification
  // ----------------------------------------
  always_comb begin
    if (!cfg.en) begin
      fn = tpio_pkg::TPIO_FN_OFF;
    end else if (!cfg.field[`TPIO_FLD_TOP]) begin
      fn = tpio_pkg::TPIO_FN_OC;
    end else if (cfg.field[`TPIO_FLD_LVL]) begin
      fn = tpio_pkg::TPIO_FN_OFF;
    end else begin
      fn = tpio_pkg::TPIO_FN_IC;
    end
    rise = st.sync2 & ~st.prev;
    fall = ~st.sync2 & st.prev;
    if (cfg.field[1]) begin
      qual = rise | fall;
    end else if (cfg.field[0]) begin
      qual = fall;
    end else begin
      qual = rise;
    end
    next_st = st;
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    next_st.hit = qual && (fn == tpio_pkg::TPIO_FN_IC);
    // a config change after the edge must not let a late strobe out
    next_st.cap_stb = st.hit && (fn == tpio_pkg::TPIO_FN_IC);
    if (st.hit && fn == tpio_pkg::TPIO_FN_IC) begin
      next_st.cap_val = count;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cap_stb = st.cap_stb;
  assign cap_val = st.cap_val;

  capture_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st.hit && fn == tpio_pkg::TPIO_FN_IC) |=> (cap_stb && cap_val == $past(count)))
    else $error("capture not recorded one cycle after edge");

  rise_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.en && cfg.field == 4'h8 && st.sync2 && !st.prev) |=> st.hit)
    else $error("rising edge not taken");

endmodule

// ==== tpio_io_ctrl.sv ====
`timescale 1ns/1ps
`include "tpio_params.svh"

// How it works
// - channel 0 has a high and a low control register, channels 1 and 2 one each.
// - each 8-bit control register holds a B/D field in bits 7:4 and A/C in 3:0, RW, reset 0.
// - the channel mode setting (PWM, buffering) changes how the fields act.
// - the initial pin level is applied while the channel's run bit is 0, and at counter clear in PWM mode 2.
// - in PWM mode 2 the field level is driven onto the pin when the counter clears.
// - a C or D register used as buffer has its field ignored: no capture, no compare.
// - top bit 0 selects output compare, bit 2 is the initial level.
// - compare action bits 1:0: 00 no output, 01 low, 10 high, 11 toggle.
// - top bit 1 with bit 2 clear captures on rise, fall or both; bit 2 set is prohibited.
// - capture samples the pin of the same register and records the counter value.
// - buffer bit A pairs A with C, buffer bit B pairs B with D.
module tpio_io_ctrl #(
  parameter int CW = `TPIO_CW
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [15:0] COUNT_CH0,
  input wire logic [15:0] COUNT_CH1,
  input wire logic [15:0] COUNT_CH2,
  input wire logic [7:0] CMP_MATCH,
  input wire logic [2:0] CNT_CLEAR,
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output logic [7:0] CAP_STB
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  generate
    if (CW != 16) begin : g_bad_cw
      $error("counter width must be 16");
    end
  endgenerate

  tpio_pkg::tpio_regs_t st;
  tpio_pkg::tpio_regs_t next_st;

  logic [2:0][15:0] count;
  logic [7:0][3:0] fld;
  logic [7:0][15:0] cap_val;
  logic [7:0] inval;
  logic [7:0] run_k;
  logic [7:0] pwm1_k;
  logic [7:0] pwm2_k;
  logic [7:0] clr_k;
  logic bus_req;
  logic wr_lane;

  assign count[0] = COUNT_CH0;
  assign count[1] = COUNT_CH1;
  assign count[2] = COUNT_CH2;

  // ----------------------------------------
  // per register decode and capture units
  // ----------------------------------------
  // unit k: 0..3 are A,B,C,D of channel 0, 4,5 channel 1, 6,7 channel 2
  generate
    for (genvar k = 0; k < 8; k++) begin : g_unit
      localparam int CH = (k < 4) ? 0 : ((k < 6) ? 1 : 2);
      tpio_pkg::tpio_cfg_t cfg;

      assign fld[k] = st.io[k / 2][4 * (k % 2) +: 4];
      assign run_k[k] = st.run[CH];
      assign pwm1_k[k] = (st.mode[CH][3:0] == `TPIO_MD_PWM1);
      assign pwm2_k[k] = (st.mode[CH][3:0] == `TPIO_MD_PWM2);
      assign clr_k[k] = CNT_CLEAR[CH];
      if (k == 2) begin : g_buf_c
        assign inval[k] = st.mode[0][`TPIO_MODE_BFA];
      end else if (k == 3) begin : g_buf_d
        assign inval[k] = st.mode[0][`TPIO_MODE_BFB];
      end else begin : g_buf_none
        assign inval[k] = 1'b0;
      end
      // no capture in PWM modes, the pins are outputs there
      assign cfg = {fld[k], !inval[k] && !pwm1_k[k] && !pwm2_k[k]};

      tpio_cap_unit u_cap (
        .clk(MCLK),
        .rst_n(RST_N),
        .pin_in(PIN_IN[k]),
        .cfg(cfg),
        .count(count[CH]),
        .cap_stb(CAP_STB[k]),
        .cap_val(cap_val[k])
      );

      init_level_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!run_k[k] && !fld[k][`TPIO_FLD_TOP] && !inval[k])
          |=> (PIN_OUT[k] == $past(fld[k][`TPIO_FLD_LVL])))
        else $error("initial level not applied while stopped");

      match_low_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (run_k[k] && !pwm1_k[k] && !fld[k][`TPIO_FLD_TOP] && !inval[k] && CMP_MATCH[k]
          && fld[k][1:0] == `TPIO_ACT_LOW && !(pwm2_k[k] && clr_k[k]))
          |=> !PIN_OUT[k])
        else $error("compare match did not drive low");

      match_toggle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (run_k[k] && !pwm1_k[k] && !fld[k][`TPIO_FLD_TOP] && !inval[k] && CMP_MATCH[k]
          && fld[k][1:0] == `TPIO_ACT_TOG && !(pwm2_k[k] && clr_k[k]))
          |=> (PIN_OUT[k] != $past(PIN_OUT[k])))
        else $error("compare match did not toggle");

      pwm2_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (run_k[k] && pwm2_k[k] && clr_k[k] && !fld[k][`TPIO_FLD_TOP] && !inval[k])
          |=> (PIN_OUT[k] == $past(fld[k][`TPIO_FLD_LVL])))
        else $error("clear level not applied in pwm mode 2");

      buffer_off_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        inval[k] |=> (!PIN_OE[k] && !CAP_STB[k]))
        else $error("buffer register still active");

      prohibited_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (fld[k][3:2] == 2'h3) |=> (!PIN_OE[k] && !CAP_STB[k]))
        else $error("prohibited code not idle");

      oe_off_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!fld[k][`TPIO_FLD_TOP] && !inval[k] && !pwm1_k[k])
          |=> (PIN_OE[k] == ($past(fld[k][1:0]) != `TPIO_ACT_OFF)))
        else $error("output enable does not follow action bits");
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  assign bus_req = WB_CYC_I && WB_STB_I && !st.ack;
  assign wr_lane = bus_req && WB_WE_I && WB_SEL_I[0];

  always_comb begin
    logic [1:0] act;
    logic lvl;
    logic oc;
    int p;
    act = `TPIO_ACT_OFF;
    lvl = 1'b0;
    oc = 1'b0;
    p = 0;
    next_st = st;

    // pin drivers
    for (int k = 0; k < 8; k++) begin
      p = k ^ 1;
      act = fld[k][1:0];
      lvl = fld[k][`TPIO_FLD_LVL];
      oc = !fld[k][`TPIO_FLD_TOP] && !inval[k];
      if (!oc) begin
        // capture, prohibited or buffer: pin left undriven
        next_st.pin_oe[k] = 1'b0;
      end else if (pwm1_k[k] && k[0]) begin
        // pwm mode 1: the B/D pin gives way to its A/C partner
        next_st.pin_oe[k] = 1'b0;
        next_st.pin_out[k] = lvl;
      end else begin
        next_st.pin_oe[k] = (act != `TPIO_ACT_OFF);
        if (!run_k[k]) begin
          next_st.pin_out[k] = lvl;
        end else if (pwm2_k[k] && clr_k[k]) begin
          next_st.pin_out[k] = lvl;
        end else if (CMP_MATCH[k]) begin
          case (act)
            `TPIO_ACT_LOW: begin
              next_st.pin_out[k] = 1'b0;
            end
            `TPIO_ACT_HIGH: begin
              next_st.pin_out[k] = 1'b1;
            end
            `TPIO_ACT_TOG: begin
              next_st.pin_out[k] = ~st.pin_out[k];
            end
            default: begin
              next_st.pin_out[k] = st.pin_out[k];
            end
          endcase
        end else if (pwm1_k[k] && CMP_MATCH[p] && !inval[p]) begin
          // partner match ends the pulse with the partner's action
          case (fld[p][1:0])
            `TPIO_ACT_LOW: begin
              next_st.pin_out[k] = 1'b0;
            end
            `TPIO_ACT_HIGH: begin
              next_st.pin_out[k] = 1'b1;
            end
            `TPIO_ACT_TOG: begin
              next_st.pin_out[k] = ~st.pin_out[k];
            end
            default: begin
              next_st.pin_out[k] = st.pin_out[k];
            end
          endcase
        end
      end
    end

    // bus slave: answer one cycle after the strobe, then drop
    next_st.ack = bus_req;
    if (bus_req) begin
      next_st.rdat = 32'h0000_0000;
      if (WB_ADR_I == `TPIO_OFS_IO_HI0) begin
        next_st.rdat[7:0] = st.io[0];
        if (wr_lane) begin
          next_st.io[0] = WB_DAT_I[7:0];
        end
      end else if (WB_ADR_I == `TPIO_OFS_IO_LO0) begin
        next_st.rdat[7:0] = st.io[1];
        if (wr_lane) begin
          next_st.io[1] = WB_DAT_I[7:0];
        end
      end else if (WB_ADR_I == `TPIO_OFS_IO_CH1) begin
        next_st.rdat[7:0] = st.io[2];
        if (wr_lane) begin
          next_st.io[2] = WB_DAT_I[7:0];
        end
      end else if (WB_ADR_I == `TPIO_OFS_IO_CH2) begin
        next_st.rdat[7:0] = st.io[3];
        if (wr_lane) begin
          next_st.io[3] = WB_DAT_I[7:0];
        end
      end else if (WB_ADR_I == `TPIO_OFS_MODE0) begin
        next_st.rdat[7:0] = {`TPIO_MODE_RSVD, st.mode[0]};
        if (wr_lane) begin
          next_st.mode[0] = WB_DAT_I[5:0];
        end
      end else if (WB_ADR_I == `TPIO_OFS_MODE1) begin
        // no C or D here, so the buffer bits stay zero
        next_st.rdat[7:0] = {`TPIO_MODE_RSVD, st.mode[1]};
        if (wr_lane) begin
          next_st.mode[1] = {2'h0, WB_DAT_I[3:0]};
        end
      end else if (WB_ADR_I == `TPIO_OFS_MODE2) begin
        next_st.rdat[7:0] = {`TPIO_MODE_RSVD, st.mode[2]};
        if (wr_lane) begin
          next_st.mode[2] = {2'h0, WB_DAT_I[3:0]};
        end
      end else if (WB_ADR_I == `TPIO_OFS_START) begin
        next_st.rdat[2:0] = st.run;
        if (wr_lane) begin
          next_st.run = WB_DAT_I[2:0];
        end
      end else if (WB_ADR_I[7:5] == 3'(`TPIO_OFS_CAP_BASE >> 5) && WB_ADR_I[1:0] == 2'h0) begin
        // capture values are read only
        next_st.rdat[15:0] = cap_val[WB_ADR_I[4:2]];
      end else begin
        next_st.rdat = 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign WB_DAT_O = st.rdat;
  assign WB_ACK_O = st.ack;
  assign PIN_OUT = st.pin_out;
  assign PIN_OE = st.pin_oe;

  // ----------------------------------------
  // bus and register checks
  // ----------------------------------------
  wb_ack_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> (WB_ACK_O ##1 !WB_ACK_O))
    else $error("ack not single cycle after strobe");

  io_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0]
      && WB_ADR_I == `TPIO_OFS_IO_LO0) |=> (st.io[1] == $past(WB_DAT_I[7:0])))
    else $error("control register write lost");

  buf_pair_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st.mode[0][`TPIO_MODE_BFB] |-> inval[3]) and (!st.mode[0][`TPIO_MODE_BFA] |-> !inval[2]))
    else $error("buffer pairing wrong");

endmodule

// ==== tpio_pin_model.sv ====
`timescale 1ns/1ps

module tpio_pin_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_lvl,
  output logic [7:0] pin_in
);
  // ----------------------------------------
  // pin wires
  // ----------------------------------------
  // a driven pin reads back its own level, a released one follows the outside source
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_in[k] = pin_oe[k] ? pin_out[k] : ext_lvl[k];
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "tpio_params.svh"

module tb_top;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] cnt0 = 16'h0000;
  logic [15:0] cnt1 = 16'h0000;
  logic [15:0] cnt2 = 16'h0000;
  logic [7:0] cmp = 8'h00;
  logic [2:0] clr = 3'h0;
  logic [7:0] ext = 8'h00;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] cap_stb;
  int fails = 0;
  int compares = 0;

  always #2 MCLK = ~MCLK;

  tpio_io_ctrl #(.CW(16)) i_tpio_io_ctrl (
    .MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .COUNT_CH0(cnt0), .COUNT_CH1(cnt1), .COUNT_CH2(cnt2), .CMP_MATCH(cmp),
    .CNT_CLEAR(clr), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CAP_STB(cap_stb)
  );

  tpio_pin_model i_tpio_pin_model (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .pin_in(pin_in)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // bounded wait: the slave latency is not assumed
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge MCLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge MCLK);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      chk(ack, 1'b1, "bus timeout");
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(q, exp, "register read");
  endtask

  task automatic pulse(input logic [7:0] m, input logic [2:0] c);
    @(posedge MCLK);
    cmp <= m;
    clr <= c;
    @(posedge MCLK);
    cmp <= 8'h00;
    clr <= 3'h0;
    repeat (2) @(posedge MCLK);
  endtask

  // drives one pin edge and judges the capture against the unit's own counter
  task automatic cap_edge(input int u, input logic lvl, input logic hit, input logic [15:0] c);
    logic seen;
    logic [31:0] q;
    logic [15:0] want;
    seen = 1'b0;
    want = c + 16'h0100 * 16'(u < 4 ? 0 : (u < 6 ? 1 : 2));
    @(posedge MCLK);
    cnt0 <= c;
    cnt1 <= c + 16'h0100;
    cnt2 <= c + 16'h0200;
    ext[u] <= lvl;
    repeat (8) begin
      @(posedge MCLK);
      if (cap_stb[u] === 1'b1) seen = 1'b1;
    end
    chk(seen, hit, "capture strobe");
    if (hit) begin
      bus(8'h20 + 8'(4 * u), 1'b0, 8'h00, q);
      chk(q, {16'h0000, want}, "capture value");
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] ofs[4];
    ofs = '{`TPIO_OFS_IO_HI0, `TPIO_OFS_IO_LO0, `TPIO_OFS_IO_CH1, `TPIO_OFS_IO_CH2};
    for (int i = 0; i < 4; i++) rd_chk(ofs[i], 32'h0000_0000);
    for (int i = 0; i < 4; i++) wr(ofs[i], 8'h5A + 8'(i * 17));
    for (int i = 0; i < 4; i++) rd_chk(ofs[i], 32'(8'h5A + 8'(i * 17)));
    wr(8'hF0, 8'hFF);
    rd_chk(8'hF0, 32'h0000_0000);
    wr(`TPIO_OFS_MODE0, 8'h30);
    rd_chk(`TPIO_OFS_MODE0, 32'h0000_00F0);
    wr(`TPIO_OFS_MODE1, 8'h31);
    rd_chk(`TPIO_OFS_MODE1, 32'h0000_00C1);
    wr(`TPIO_OFS_START, 8'h05);
    rd_chk(`TPIO_OFS_START, 32'h0000_0005);
    wr(`TPIO_OFS_MODE0, 8'h00);
    wr(`TPIO_OFS_MODE1, 8'h00);
    wr(`TPIO_OFS_START, 8'h00);
    for (int i = 0; i < 4; i++) wr(ofs[i], 8'h00);
  endtask

  task automatic t_compare();
    logic exp;
    for (int l = 0; l < 2; l++) begin
      for (int a = 0; a < 4; a++) begin
        wr(`TPIO_OFS_START, 8'h00);
        wr(`TPIO_OFS_IO_HI0, {5'h00, l[0], a[1:0]});
        repeat (2) @(posedge MCLK);
        chk(pin_out[0], l[0], "initial level");
        wr(`TPIO_OFS_START, 8'h01);
        pulse(8'h01, 3'h0);
        exp = (a == 1) ? 1'b0 : ((a == 2) ? 1'b1 : ~l[0]);
        if (a != 0) chk(pin_out[0], exp, "match action");
        chk(pin_oe[0], a != 0, "match enable");
        wr(`TPIO_OFS_START, 8'h00);
        repeat (2) @(posedge MCLK);
        chk(pin_out[0], l[0], "stopped level");
      end
    end
  endtask

  task automatic t_pwm2();
    wr(`TPIO_OFS_MODE0, 8'h03);
    wr(`TPIO_OFS_IO_HI0, 8'h05);
    wr(`TPIO_OFS_START, 8'h01);
    pulse(8'h01, 3'h0);
    chk(pin_out[0], 1'b0, "pwm match");
    pulse(8'h00, 3'h1);
    chk(pin_out[0], 1'b1, "pwm clear level");
    wr(`TPIO_OFS_START, 8'h00);
    wr(`TPIO_OFS_MODE0, 8'h00);
  endtask

  task automatic t_pwm1();
    wr(`TPIO_OFS_MODE0, 8'h02);
    wr(`TPIO_OFS_IO_HI0, 8'h12);
    wr(`TPIO_OFS_START, 8'h01);
    pulse(8'h01, 3'h0);
    chk(pin_out[0], 1'b1, "pwm1 own match");
    chk(pin_oe[1], 1'b0, "pwm1 partner drive");
    pulse(8'h02, 3'h0);
    chk(pin_out[0], 1'b0, "pwm1 partner match");
    chk(pin_oe[0], 1'b1, "pwm1 drive");
    wr(`TPIO_OFS_START, 8'h00);
    wr(`TPIO_OFS_MODE0, 8'h00);
  endtask

  task automatic t_capture();
    wr(`TPIO_OFS_IO_HI0, 8'h80);
    cap_edge(1, 1'b1, 1'b1, 16'h1234);
    wr(`TPIO_OFS_IO_HI0, 8'h90);
    cap_edge(1, 1'b0, 1'b1, 16'h0042);
    cap_edge(1, 1'b1, 1'b0, 16'h0043);
    wr(`TPIO_OFS_IO_HI0, 8'hA0);
    cap_edge(1, 1'b0, 1'b1, 16'h00FF);
    cap_edge(1, 1'b1, 1'b1, 16'hFFFF);
    wr(`TPIO_OFS_IO_HI0, 8'hC0);
    cap_edge(1, 1'b0, 1'b0, 16'h0007);
    chk(pin_oe[1], 1'b0, "prohibited drive");
    wr(`TPIO_OFS_IO_CH1, 8'h08);
    cap_edge(4, 1'b1, 1'b1, 16'h2000);
    wr(`TPIO_OFS_IO_CH2, 8'h80);
    cap_edge(7, 1'b1, 1'b1, 16'h3000);
  endtask

  task automatic t_buffer();
    wr(`TPIO_OFS_MODE0, 8'h10);
    wr(`TPIO_OFS_IO_LO0, 8'h08);
    cap_edge(2, 1'b1, 1'b0, 16'h0ABC);
    wr(`TPIO_OFS_IO_LO0, 8'h55);
    repeat (2) @(posedge MCLK);
    chk(pin_oe[2], 1'b0, "buffer drive");
    chk(pin_oe[3], 1'b1, "unpaired drive");
    wr(`TPIO_OFS_MODE0, 8'h20);
    repeat (2) @(posedge MCLK);
    chk(pin_oe[2], 1'b1, "unbuffered drive");
    chk(pin_oe[3], 1'b0, "paired drive");
  endtask

  initial begin
    repeat (16) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    chk(pin_oe, 8'h00, "reset drive");
    t_regs();
    t_compare();
    t_pwm2();
    t_pwm1();
    t_capture();
    t_buffer();
    report_and_stop();
  end
endmodule
